// >>> design/synth_modulator_vco_level_cfg.v
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
// Overview of operation
// - Bleed polarity: 0 negative, 1 positive
// - Readback select: VCO data or version ID
// - Half step adds half LSB, aux off
// - Fraction write resets modulator unless masked
// - Bypass bit disables modulator; resets to 1
// - Core D loop off bit, reset 0
// - Core D temperature tuning enable, reset 0
// - Rectifier bias select per core, reset 1
// - Threshold range select per core, reset 0
// - Core D nominal threshold, reset 001
// - Core C nominal threshold, reset 001
// - Core B nominal threshold, reset 000
`include "synth_cfg_regs.vh"

module synth_modulator_vco_level_cfg #(
    parameter VERSION_ID = 8'hA5 // Arbitrary value
) (
    input wire CLK,
    input wire SRST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    input wire [7:0] VCO_STATUS_DATA,
    output reg [31:0] HRDATA,
    output reg HREADYOUT,
    output reg HRESP,
    output reg BLEED_POLARITY_SEL,
    output reg RESERVED_LATCH_OPTION,
    output reg READBACK_VERSION_SEL,
    output reg [7:0] READBACK_DATA,
    output reg HALF_STEP_ADD,
    output reg AUX_MODULATOR_ENABLE,
    output reg MODULATOR_RESET_MASK,
    output reg MODULATOR_BYPASS,
    output reg MODULATOR_RESET,
    output reg [7:0] PRIMARY_FRACTION_WORD,
    output reg [7:0] SECONDARY_FRACTION_WORD,
    output reg [8:0] EFFECTIVE_FRACTION_X2,
    output reg AMPLITUDE_LOOP_OFF,
    output reg TEMP_TUNING_VOLTAGE_ENABLE,
    output reg RECTIFIER_BIAS_SEL_CORE_D,
    output reg RECTIFIER_BIAS_SEL_CORE_C,
    output reg RECTIFIER_BIAS_SEL_CORE_B,
    output reg THRESHOLD_RANGE_CORE_D,
    output reg THRESHOLD_RANGE_CORE_C,
    output reg THRESHOLD_RANGE_CORE_B,
    output reg [2:0] NOMINAL_THRESHOLD_CORE_D,
    output reg [2:0] NOMINAL_THRESHOLD_CORE_C,
    output reg [2:0] NOMINAL_THRESHOLD_CORE_B
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    reg [7:0] bleed_rb_ff;
    reg [7:0] mod_ctrl_ff;
    reg [7:0] core_d_ff;
    reg [7:0] core_c_ff;
    reg [7:0] core_b_ff;
    reg [7:0] frac_pri_ff;
    reg [7:0] frac_sec_ff;
    reg wr_pend_ff;
    reg [7:0] wr_idx_ff;
    reg [7:0] nxt_rdata;

    wire addr_phase;
    wire [7:0] a_idx;
    wire wr_now;
    wire [7:0] wbyte;

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------
    // Upper address bits ignored; only word index decoded
    assign addr_phase = HSEL && HREADY && (HTRANS == `HTRANS_NONSEQ);
    assign a_idx = HADDR[9:2];
    assign wr_now = wr_pend_ff;
    assign wbyte = HWDATA[7:0];

    // Read mux: unmapped reads return zero
    always @* begin
        if (a_idx == `IDX_BLEED_READBACK) begin
            nxt_rdata = bleed_rb_ff & `WMASK_BLEED_READBACK;
        end else if (a_idx == `IDX_MOD_CTRL) begin
            nxt_rdata = mod_ctrl_ff & `WMASK_MOD_CTRL;
        end else if (a_idx == `IDX_CORE_D) begin
            nxt_rdata = core_d_ff & `WMASK_CORE_D;
        end else if (a_idx == `IDX_CORE_C) begin
            nxt_rdata = core_c_ff & `WMASK_CORE_CB;
        end else if (a_idx == `IDX_CORE_B) begin
            nxt_rdata = core_b_ff & `WMASK_CORE_CB;
        end else if (a_idx == `IDX_FRAC_PRIMARY) begin
            nxt_rdata = frac_pri_ff;
        end else if (a_idx == `IDX_FRAC_SECONDARY) begin
            nxt_rdata = frac_sec_ff;
        end else if (a_idx == `IDX_RB_DATA) begin
            nxt_rdata = bleed_rb_ff[`BIT_READ_SEL] ? VERSION_ID : VCO_STATUS_DATA;
        end else begin
            nxt_rdata = 8'h00;
        end
    end

    always @(posedge CLK) begin
        if (SRST) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 8'h00;
            HRDATA <= 32'h00000000;
            HREADYOUT <= 1'b1;
            HRESP <= `HRESP_OKAY;
        end else begin
            wr_pend_ff <= addr_phase && HWRITE;
            wr_idx_ff <= a_idx;
            HREADYOUT <= 1'b1;
            HRESP <= `HRESP_OKAY;
            if (addr_phase && !HWRITE) begin
                HRDATA <= {24'h000000, nxt_rdata};
            end
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always @(posedge CLK) begin
        if (SRST) begin
            bleed_rb_ff <= `RST_BLEED_READBACK;
            mod_ctrl_ff <= `RST_MOD_CTRL;
            core_d_ff <= `RST_CORE_D;
            core_c_ff <= `RST_CORE_C;
            core_b_ff <= `RST_CORE_B;
            frac_pri_ff <= `RST_FRAC;
            frac_sec_ff <= `RST_FRAC;
        end else if (wr_now) begin
            // Reserved read-only bits never stored
            if (wr_idx_ff == `IDX_BLEED_READBACK) begin
                bleed_rb_ff <= wbyte & `WMASK_BLEED_READBACK;
            end else if (wr_idx_ff == `IDX_MOD_CTRL) begin
                mod_ctrl_ff <= wbyte & `WMASK_MOD_CTRL;
            end else if (wr_idx_ff == `IDX_CORE_D) begin
                core_d_ff <= wbyte & `WMASK_CORE_D;
            end else if (wr_idx_ff == `IDX_CORE_C) begin
                core_c_ff <= wbyte & `WMASK_CORE_CB;
            end else if (wr_idx_ff == `IDX_CORE_B) begin
                core_b_ff <= wbyte & `WMASK_CORE_CB;
            end else if (wr_idx_ff == `IDX_FRAC_PRIMARY) begin
                frac_pri_ff <= wbyte;
            end else if (wr_idx_ff == `IDX_FRAC_SECONDARY) begin
                frac_sec_ff <= wbyte;
            end
        end
    end

    // ------------------------------------------------------------
    // Control outputs, one cycle behind the register file
    // ------------------------------------------------------------
    always @(posedge CLK) begin
        if (SRST) begin
            BLEED_POLARITY_SEL <= 1'b0;
            RESERVED_LATCH_OPTION <= 1'b0;
            READBACK_VERSION_SEL <= 1'b0;
            READBACK_DATA <= 8'h00;
            HALF_STEP_ADD <= 1'b0;
            AUX_MODULATOR_ENABLE <= 1'b0;
            MODULATOR_RESET_MASK <= 1'b0;
            MODULATOR_BYPASS <= 1'b1;
            MODULATOR_RESET <= 1'b0;
            PRIMARY_FRACTION_WORD <= 8'h00;
            SECONDARY_FRACTION_WORD <= 8'h00;
            EFFECTIVE_FRACTION_X2 <= 9'h000;
            AMPLITUDE_LOOP_OFF <= 1'b0;
            TEMP_TUNING_VOLTAGE_ENABLE <= 1'b0;
            RECTIFIER_BIAS_SEL_CORE_D <= 1'b1;
            RECTIFIER_BIAS_SEL_CORE_C <= 1'b1;
            RECTIFIER_BIAS_SEL_CORE_B <= 1'b1;
            THRESHOLD_RANGE_CORE_D <= 1'b0;
            THRESHOLD_RANGE_CORE_C <= 1'b0;
            THRESHOLD_RANGE_CORE_B <= 1'b0;
            NOMINAL_THRESHOLD_CORE_D <= 3'h1;
            NOMINAL_THRESHOLD_CORE_C <= 3'h1;
            NOMINAL_THRESHOLD_CORE_B <= 3'h0;
        end else begin
            BLEED_POLARITY_SEL <= bleed_rb_ff[`BIT_BLEED_POLARITY_SEL];
            RESERVED_LATCH_OPTION <= bleed_rb_ff[`BIT_LATCH_OPT];
            READBACK_VERSION_SEL <= bleed_rb_ff[`BIT_READ_SEL];
            READBACK_DATA <= bleed_rb_ff[`BIT_READ_SEL] ? VERSION_ID : VCO_STATUS_DATA;
            HALF_STEP_ADD <= mod_ctrl_ff[`BIT_HALF_STEP];
            AUX_MODULATOR_ENABLE <= mod_ctrl_ff[`BIT_AUX_EN];
            MODULATOR_RESET_MASK <= mod_ctrl_ff[`BIT_RST_MASK];
            MODULATOR_BYPASS <= mod_ctrl_ff[`BIT_BYPASS];
            // One-cycle pulse per unmasked fraction word write
            MODULATOR_RESET <= wr_now && (wr_idx_ff == `IDX_FRAC_WORD) &&
                !mod_ctrl_ff[`BIT_RST_MASK];
            PRIMARY_FRACTION_WORD <= frac_pri_ff;
            SECONDARY_FRACTION_WORD <= frac_sec_ff;
            // Doubled so the half LSB is visible; zero while bypassed
            if (mod_ctrl_ff[`BIT_BYPASS]) begin
                EFFECTIVE_FRACTION_X2 <= 9'h000;
            end else begin
                EFFECTIVE_FRACTION_X2 <= {frac_pri_ff, mod_ctrl_ff[`BIT_HALF_STEP] &&
                    !mod_ctrl_ff[`BIT_AUX_EN]};
            end
            AMPLITUDE_LOOP_OFF <= core_d_ff[`BIT_LOOP_OFF];
            TEMP_TUNING_VOLTAGE_ENABLE <= core_d_ff[`BIT_TEMP_EN];
            RECTIFIER_BIAS_SEL_CORE_D <= core_d_ff[`BIT_RECT_D];
            RECTIFIER_BIAS_SEL_CORE_C <= core_c_ff[`BIT_RECT_CB];
            RECTIFIER_BIAS_SEL_CORE_B <= core_b_ff[`BIT_RECT_CB];
            THRESHOLD_RANGE_CORE_D <= core_d_ff[`BIT_RANGE_D];
            THRESHOLD_RANGE_CORE_C <= core_c_ff[`BIT_RANGE_CB];
            THRESHOLD_RANGE_CORE_B <= core_b_ff[`BIT_RANGE_CB];
            NOMINAL_THRESHOLD_CORE_D <= core_d_ff[`NOM_D_HI:`NOM_D_LO];
            NOMINAL_THRESHOLD_CORE_C <= core_c_ff[`NOM_CB_HI:`NOM_CB_LO];
            NOMINAL_THRESHOLD_CORE_B <= core_b_ff[`NOM_CB_HI:`NOM_CB_LO];
        end
    end

endmodule // synth_modulator_vco_level_cfg

// >>> design/synth_cfg_regs.vh
`ifndef SYNTH_CFG_REGS_VH
`define SYNTH_CFG_REGS_VH

// ------------------------------------------------------------
// Register indices (byte address = index * 4)
// ------------------------------------------------------------
`define IDX_BLEED_READBACK 8'h2A
`define IDX_MOD_CTRL 8'h2B
`define IDX_CORE_D 8'h2C
`define IDX_CORE_C 8'h2D
`define IDX_CORE_B 8'h2E
`define IDX_FRAC_WORD 8'h10
`define IDX_FRAC_PRIMARY 8'h30
`define IDX_FRAC_SECONDARY 8'h31
`define IDX_RB_DATA 8'h32

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_BLEED_READBACK 8'h00
`define RST_MOD_CTRL 8'h01
`define RST_CORE_D 8'h44
`define RST_CORE_C 8'h11
`define RST_CORE_B 8'h10
`define RST_FRAC 8'h00

// ------------------------------------------------------------
// Writable bit masks
// ------------------------------------------------------------
`define WMASK_BLEED_READBACK 8'h29
`define WMASK_MOD_CTRL 8'h35
`define WMASK_CORE_D 8'h7F
`define WMASK_CORE_CB 8'h1F

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_BLEED_POLARITY_SEL 5
`define BIT_LATCH_OPT 3
`define BIT_READ_SEL 0
`define BIT_HALF_STEP 5
`define BIT_AUX_EN 4
`define BIT_RST_MASK 2
`define BIT_BYPASS 0
`define BIT_RECT_D 6
`define BIT_RANGE_D 5
`define NOM_D_HI 4
`define NOM_D_LO 2
`define BIT_TEMP_EN 1
`define BIT_LOOP_OFF 0
`define BIT_RECT_CB 4
`define BIT_RANGE_CB 3
`define NOM_CB_HI 2
`define NOM_CB_LO 0

// ------------------------------------------------------------
// AHB encodings
// ------------------------------------------------------------
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'h0

`endif

// >>> tb/synth_cfg_chk.sv
`timescale 1ns/1ps
module synth_cfg_chk #(
    parameter VERSION_ID = 8'hA5
) (
    input wire CLK,
    input wire SRST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    input wire [7:0] VCO_STATUS_DATA,
    input wire [31:0] HRDATA,
    input wire BLEED_POLARITY_SEL,
    input wire READBACK_VERSION_SEL,
    input wire [7:0] READBACK_DATA,
    input wire HALF_STEP_ADD,
    input wire AUX_MODULATOR_ENABLE,
    input wire MODULATOR_RESET_MASK,
    input wire MODULATOR_BYPASS,
    input wire MODULATOR_RESET,
    input wire [7:0] PRIMARY_FRACTION_WORD,
    input wire [8:0] EFFECTIVE_FRACTION_X2,
    input wire AMPLITUDE_LOOP_OFF,
    input wire TEMP_TUNING_VOLTAGE_ENABLE,
    input wire RECTIFIER_BIAS_SEL_CORE_D,
    input wire THRESHOLD_RANGE_CORE_D,
    input wire [2:0] NOMINAL_THRESHOLD_CORE_D
);
    // ----------------------------------------
    // Write address phase decode
    // ----------------------------------------
    wire wr = HSEL & HREADY & (HTRANS == 2'h2) & HWRITE;
    wire [7:0] idx = HADDR[9:2];
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    property p_hi_zero; HRDATA[31:8] == 24'h000000; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
    property p_sd_rst; wr && idx == 8'h10 && !MODULATOR_RESET_MASK |-> ##2 MODULATOR_RESET; endproperty
    a_sd_rst: assert property (p_sd_rst) else $error("no modulator reset pulse");
    property p_sd_mask; wr && idx == 8'h10 && MODULATOR_RESET_MASK |-> ##2 !MODULATOR_RESET; endproperty
    a_sd_mask: assert property (p_sd_mask) else $error("masked reset pulsed");
    property p_readback;
        !$past(SRST) |-> READBACK_DATA ==
            (READBACK_VERSION_SEL ? VERSION_ID : $past(VCO_STATUS_DATA));
    endproperty
    a_readback: assert property (p_readback) else $error("readback source wrong");
    property p_eff;
        EFFECTIVE_FRACTION_X2 == (MODULATOR_BYPASS ? 9'h000 :
            {PRIMARY_FRACTION_WORD, HALF_STEP_ADD & ~AUX_MODULATOR_ENABLE});
    endproperty
    a_eff: assert property (p_eff) else $error("effective fraction wrong");
    property p_core_d;
        wr && idx == 8'h2C |-> ##3 {RECTIFIER_BIAS_SEL_CORE_D, THRESHOLD_RANGE_CORE_D,
            NOMINAL_THRESHOLD_CORE_D, TEMP_TUNING_VOLTAGE_ENABLE, AMPLITUDE_LOOP_OFF}
            == $past(HWDATA[6:0], 2);
    endproperty
    a_core_d: assert property (p_core_d) else $error("core D fields wrong");
    property p_bleed;
        wr && idx == 8'h2A |-> ##3
            {BLEED_POLARITY_SEL, READBACK_VERSION_SEL} ==
            {$past(HWDATA[5], 2), $past(HWDATA[0], 2)};
    endproperty
    a_bleed: assert property (p_bleed) else $error("bleed or select wrong");
    property p_mod;
        wr && idx == 8'h2B |-> ##3
            {HALF_STEP_ADD, AUX_MODULATOR_ENABLE, MODULATOR_RESET_MASK, MODULATOR_BYPASS} ==
            {$past(HWDATA[5], 2), $past(HWDATA[4], 2), $past(HWDATA[2], 2),
            $past(HWDATA[0], 2)};
    endproperty
    a_mod: assert property (p_mod) else $error("modulator control wrong");
    c_sd: cover property (MODULATOR_RESET);
    c_rb: cover property (READBACK_VERSION_SEL && READBACK_DATA == VERSION_ID);
    c_half: cover property (EFFECTIVE_FRACTION_X2[0]);
endmodule // synth_cfg_chk

bind synth_modulator_vco_level_cfg synth_cfg_chk #(.VERSION_ID(VERSION_ID)) chk_i (.*);

// >>> tb/synth_modulator_vco_level_cfg_tb_top.sv
`timescale 1ns/1ps
module synth_modulator_vco_level_cfg_tb_top;
    localparam [39:0] RV = 40'h0001441110;
    localparam [39:0] WM = 40'h29357F1F1F;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg [31:0] haddr = 32'h00000000;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h00000000;
    reg [7:0] vco = 8'h00;
    reg [31:0] q;
    wire [31:0] hrdata;
    wire rdy, bleed, rsel, half, aux, mask, byp, mrst, loff, temp;
    wire rect_d, rect_c, rect_b, rng_d, rng_c, rng_b, resp, latch;
    wire [7:0] rbd, prim, sec;
    wire [8:0] eff;
    wire [2:0] nom_d, nom_c, nom_b;
    integer failures = 0;
    integer checks = 0;
    integer pulses = 0;
    always #4 clk = ~clk;
    always @(posedge clk) if (mrst) pulses <= pulses + 1;
    // Version value is arbitrary
    synth_modulator_vco_level_cfg #(.VERSION_ID(8'h5C)) DUT (
        .CLK(clk), .SRST(srst), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(rdy), .VCO_STATUS_DATA(vco), .HRDATA(hrdata),
        .HREADYOUT(rdy), .HRESP(resp), .BLEED_POLARITY_SEL(bleed), .RESERVED_LATCH_OPTION(latch),
        .READBACK_VERSION_SEL(rsel), .READBACK_DATA(rbd), .HALF_STEP_ADD(half),
        .AUX_MODULATOR_ENABLE(aux), .MODULATOR_RESET_MASK(mask), .MODULATOR_BYPASS(byp),
        .MODULATOR_RESET(mrst), .PRIMARY_FRACTION_WORD(prim), .SECONDARY_FRACTION_WORD(sec),
        .EFFECTIVE_FRACTION_X2(eff), .AMPLITUDE_LOOP_OFF(loff), .TEMP_TUNING_VOLTAGE_ENABLE(temp),
        .RECTIFIER_BIAS_SEL_CORE_D(rect_d), .RECTIFIER_BIAS_SEL_CORE_C(rect_c),
        .RECTIFIER_BIAS_SEL_CORE_B(rect_b), .THRESHOLD_RANGE_CORE_D(rng_d),
        .THRESHOLD_RANGE_CORE_C(rng_c), .THRESHOLD_RANGE_CORE_B(rng_b),
        .NOMINAL_THRESHOLD_CORE_D(nom_d), .NOMINAL_THRESHOLD_CORE_C(nom_c),
        .NOMINAL_THRESHOLD_CORE_B(nom_b));
    // ----------------------------------------
    // Bus and check helpers
    // ----------------------------------------
    task chk(input [31:0] s, input [31:0] e);
        begin
            checks = checks + 1;
            if (s !== e) begin
                failures = failures + 1;
                $display("[FAIL] %0t saw %h expected %h", $time, s, e);
            end
        end
    endtask
    // Never assumes a wait count; waits on the slave's ready
    task xfer(input w, input [31:0] a, input [31:0] d);
        begin
            @(posedge clk);
            haddr <= a;
            htrans <= 2'h2;
            hwrite <= w;
            @(posedge clk);
            while (!rdy) @(posedge clk);
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge clk);
            while (!rdy) @(posedge clk);
            q = hrdata;
        end
    endtask
    task settle;
        begin
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d failures %0d", checks, failures);
            if (failures == 0 && checks > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        integer i;
        begin
            for (i = 0; i < 5; i = i + 1) begin
                xfer(1'b0, 32'hA8 + 4 * i, 32'h0);
                chk(q, RV[39 - 8 * i -: 8]);
            end
            chk({byp, rect_d, rect_c, rect_b, rng_d, rng_c, rng_b, nom_d, nom_c, nom_b, loff, temp,
                bleed, rsel, half, aux, mask}, {4'hF, 3'h0, 9'h048, 7'h00});
            chk({resp, latch, prim, sec}, 18'h00000);
        end
    endtask
    task t_access;
        integer i;
        begin
            for (i = 0; i < 5; i = i + 1) begin
                xfer(1'b1, 32'hA8 + 4 * i, 32'hFFFFFFFF);
                xfer(1'b0, 32'hA8 + 4 * i, 32'h0);
                chk(q, WM[39 - 8 * i -: 8]);
                xfer(1'b1, 32'hA8 + 4 * i, 32'h0);
                xfer(1'b0, 32'hA8 + 4 * i, 32'h0);
                chk(q, 32'h0);
            end
            xfer(1'b0, 32'h3FC, 32'h0);
            chk(q, 32'h0);
        end
    endtask
    task t_fields;
        begin
            xfer(1'b1, 32'hA8, 32'h29);
            xfer(1'b1, 32'hB0, 32'h2B);
            xfer(1'b1, 32'hB4, 32'h0A);
            xfer(1'b1, 32'hB8, 32'h12);
            settle;
            chk({bleed, latch, rsel}, 3'h7);
            chk({rect_d, rng_d, nom_d, temp, loff}, 7'h2B);
            chk({rect_c, rng_c, nom_c}, 5'h0A);
            chk({rect_b, rng_b, nom_b}, 5'h12);
        end
    endtask
    task t_frac;
        begin
            xfer(1'b1, 32'hC0, 32'h5A);
            xfer(1'b1, 32'hAC, 32'h20);
            settle;
            chk(eff, 9'h0B5);
            xfer(1'b1, 32'hC4, 32'h33);
            xfer(1'b1, 32'hAC, 32'h30);
            settle;
            chk(eff, 9'h0B4);
            chk({prim, sec}, 16'h5A33);
            xfer(1'b1, 32'hAC, 32'h21);
            settle;
            chk({byp, eff}, 10'h200);
        end
    endtask
    task t_sd_reset;
        integer p;
        begin
            xfer(1'b1, 32'hAC, 32'h00);
            p = pulses;
            xfer(1'b1, 32'h40, 32'h01);
            repeat (4) @(posedge clk);
            chk(pulses, p + 1);
            xfer(1'b1, 32'hAC, 32'h04);
            xfer(1'b1, 32'h40, 32'h02);
            repeat (4) @(posedge clk);
            chk(pulses, p + 1);
        end
    endtask
    task t_readback;
        begin
            vco <= 8'h3C;
            xfer(1'b1, 32'hA8, 32'h00);
            settle;
            chk(rbd, 8'h3C);
            xfer(1'b0, 32'hC8, 32'h0);
            chk(q, 32'h3C);
            xfer(1'b1, 32'hA8, 32'h01);
            settle;
            chk(rbd, 8'h5C);
            xfer(1'b0, 32'hC8, 32'h0);
            chk(q, 32'h5C);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        t_access;
        t_fields;
        t_frac;
        t_sd_reset;
        t_readback;
        stop_test;
    end
    // Whole run needs about 1220 ns
    initial begin
        #40000;
        failures = failures + 1;
        stop_test;
    end
endmodule // synth_modulator_vco_level_cfg_tb_top
